// ==== logic/rfi_pkg.sv ====
// Constants, field layouts and carrier types for the rotor fault indicator
package rfi_pkg;

  // Configuration word indices
  localparam logic [4:0] WORD_MAX_SPEED_LOCK_OFF = 5'h0B;
  localparam logic [4:0] WORD_FAULT_THRESHOLDS = 5'h0C;
  localparam logic [4:0] WORD_FAULT_BLANK_DELAY = 5'h0D;
  localparam logic [4:0] WORD_MODE_OPTIONS = 5'h0F;

  // Field positions inside the configuration words
  localparam int LOCK_OFF_MSB = 15;
  localparam int LOCK_OFF_LSB = 8;
  localparam int MAX_ELEC_FREQ_MSB = 7;
  localparam int MAX_ELEC_FREQ_LSB = 0;
  localparam int RECOVERY_THR_MSB = 15;
  localparam int RECOVERY_THR_LSB = 8;
  localparam int FAULT_THR_MSB = 7;
  localparam int FAULT_THR_LSB = 0;
  localparam int FAULT_DELAY_MSB = 12;
  localparam int FAULT_DELAY_LSB = 8;
  localparam int BLANK_TIME_MSB = 7;
  localparam int BLANK_TIME_LSB = 0;
  localparam int LOCK_EVENT_MODE_BIT = 2;

  // Threshold scale: 16 rpm per count is a shift by four
  localparam int RPM_SCALE_SHIFT = 4;

  // Factory default lock-off time, 50 steps of 100 ms
  localparam logic [7:0] LOCK_OFF_DEFAULT = 8'h32;

  // Lock events needed to raise the flag in counting mode
  localparam logic [1:0] LOCK_COUNT_TRIP = 2'h2;

  // Timebase
  localparam int CLK_PERIOD_PS = 5000;
  localparam longint TICK_STEP_MS = 100;
  localparam longint TICK_STEP_CYCLES = (TICK_STEP_MS * 64'h3B9ACA00) / CLK_PERIOD_PS;
  localparam logic [3:0] STEPS_PER_SECOND = 4'hA;

  // Decoded fault configuration
  typedef struct packed {
    logic lock_event_mode;
    logic [7:0] recovery_speed_threshold;
    logic [7:0] fault_speed_threshold;
    logic [4:0] speed_fault_delay;
    logic [7:0] post_event_blank_time;
    logic [7:0] lock_off_time;
    logic [7:0] max_electrical_frequency;
  } rfi_cfg_s;

  // Flag state
  typedef enum logic [1:0] {
    RFI_ST_NORMAL = 2'b00,
    RFI_ST_FAULT = 2'b01,
    RFI_ST_DISABLED = 2'b10
  } rfi_state_e;

endpackage

// ==== logic/rfi_rotor_fault.sv ====
// Rotor fault indicator: lock counting, blanking, speed hysteresis and open-drain flag
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Flag pin high signals motor fault, low means normal running.
// - Counting mode: second lock event raises the flag.
// - Timed mode: lock events start blanking instead of being counted.
// - Recovery threshold in word 12 bits 15:8, 16 rpm steps; zero disables.
// - Speed fault delay in word 13 bits 12:8, whole seconds, 0 to 31.
// - Blanking interval in word 13 bits 7:0, 100 ms steps.
// - Lock-off time in word 11 bits 15:8, 100 ms steps, default 5 s.
// - Counting mode: fast speed at blanking end drops flag, clears counter.
// - Lock while running sets counter to one; recovery after blanking clears it.
// - Counting mode: speed demand off holds the flag low.
// - Timed mode: speed demand off drops the flag after the delay.
// - Blanking end with speed below recovery raises the flag.
// - After blanking, speed below fault threshold for the delay raises flag.
// - After blanking, speed above recovery for the delay drops flag.
// - Timed mode: lock while running raises flag after delay if slow.
// - Flag stays high while blanking runs, even with recovered speed.
// - Timed mode blanking end raises flag below recovery, above fault threshold.
// - Function disabled: flag goes high at end of open-loop start.
// - Lock event mode is bit 2 of word 15.
module rfi_rotor_fault #(
  parameter longint TICK_CYCLES = rfi_pkg::TICK_STEP_CYCLES
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [15:0] cfg_word11_in,
  input wire logic [15:0] cfg_word12_in,
  input wire logic [15:0] cfg_word13_in,
  input wire logic [15:0] cfg_word15_in,
  input wire logic lock_event_in,
  input wire logic [15:0] speed_rpm_in,
  input wire logic speed_demand_on_in,
  input wire logic start_done_in,
  input wire logic fault_pin_in,
  output logic fault_pin_out,
  output logic fault_pin_oe_out,
  output logic fault_state_out,
  output logic fault_pin_level_out,
  output logic lock_off_active_out,
  output logic [7:0] max_electrical_frequency_out
);

  // Timing model in brief:
  // - Every input is sampled on each rising edge; there is no handshake.
  // - The flag is registered from the next state, so it moves on the deciding edge, together with the state.
  // - Blanking, delay and lock-off count ticks of one free-running grid, so a
  //   programmed time is met to within one tick; events never restart the grid.
  // - Configuration words are static levels; a change takes effect on the next
  //   decision without flushing running timers.
  // - All outputs except the frequency pass-through and the tied-low pin data come from registers.
  // - Reset clears every timer and counter; the flag starts low, the wire held low.

  // Field extraction from the configuration words
  // Only the lock event mode bit of word 15 is used; its other bits belong elsewhere
  rfi_pkg::rfi_cfg_s cfg;
  assign cfg.lock_event_mode = cfg_word15_in[rfi_pkg::LOCK_EVENT_MODE_BIT];
  assign cfg.recovery_speed_threshold =
    cfg_word12_in[rfi_pkg::RECOVERY_THR_MSB:rfi_pkg::RECOVERY_THR_LSB];
  assign cfg.fault_speed_threshold = cfg_word12_in[rfi_pkg::FAULT_THR_MSB:rfi_pkg::FAULT_THR_LSB];
  assign cfg.speed_fault_delay = cfg_word13_in[rfi_pkg::FAULT_DELAY_MSB:rfi_pkg::FAULT_DELAY_LSB];
  assign cfg.post_event_blank_time = cfg_word13_in[rfi_pkg::BLANK_TIME_MSB:rfi_pkg::BLANK_TIME_LSB];
  assign cfg.lock_off_time = cfg_word11_in[rfi_pkg::LOCK_OFF_MSB:rfi_pkg::LOCK_OFF_LSB];
  assign cfg.max_electrical_frequency =
    cfg_word11_in[rfi_pkg::MAX_ELEC_FREQ_MSB:rfi_pkg::MAX_ELEC_FREQ_LSB];

  // Thresholds in rpm, 16 rpm per count
  // Both comparisons are strict: a speed exactly on a threshold is neither slow
  // nor fast, so the flag simply holds there
  logic [15:0] recovery_rpm;
  logic [15:0] fault_rpm;
  logic function_disabled;
  logic speed_low;
  logic speed_high;
  logic timed_mode;
  assign recovery_rpm = {4'h0, cfg.recovery_speed_threshold, 4'h0};
  assign fault_rpm = {4'h0, cfg.fault_speed_threshold, 4'h0};
  assign function_disabled = (cfg.recovery_speed_threshold == 8'h00);
  assign speed_low = (speed_rpm_in < fault_rpm);
  assign speed_high = (speed_rpm_in > recovery_rpm);
  assign timed_mode = cfg.lock_event_mode;

  // Free-running prescaler; all delays are quantised to its ticks
  // A restartable prescaler would give exact delays, but each lock event would then
  // shift the second grid too; one shared grid keeps the timers cheap and coherent
  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);
  logic [31:0] presc_q;
  logic [31:0] presc_d;
  logic [3:0] step_q;
  logic [3:0] step_d;
  logic tick_step;
  logic tick_second;
  assign tick_step = (presc_q == TICK_LAST);
  assign tick_second = tick_step && (step_q == rfi_pkg::STEPS_PER_SECOND - 4'h1);
  assign presc_d = tick_step ? 32'h0 : presc_q + 32'h1;
  assign step_d = tick_second ? 4'h0 : (tick_step ? step_q + 4'h1 : step_q);

  // Prescaler registers
  // Cleared only by reset; no event ever restarts it
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      presc_q <= 32'h0;
      step_q <= 4'h0;
    end else begin
      presc_q <= presc_d;
      step_q <= step_d;
    end
  end

  // Blanking timer, restarted by every lock event
  // A zero blanking time still passes through one cycle of blank_end, so the
  // end-of-blanking speed check runs once after each lock event
  // The end strobe is masked by a new event, so a restart never reports an end
  logic [7:0] blank_cnt_q;
  logic [7:0] blank_cnt_d;
  logic blank_run_q;
  logic blank_run_d;
  logic blank_end;
  assign blank_end = blank_run_q && (blank_cnt_q == 8'h00) && !lock_event_in;
  always_comb begin
    blank_cnt_d = blank_cnt_q;
    blank_run_d = blank_run_q;
    if (lock_event_in) begin
      blank_cnt_d = cfg.post_event_blank_time;
      blank_run_d = 1'b1;
    end else if (blank_end) begin
      blank_run_d = 1'b0;
    end else if (blank_run_q && tick_step) begin
      blank_cnt_d = blank_cnt_q - 8'h01;
    end
  end

  // Lock-off timer, the drive stays off while it runs
  // Only the status is produced here; stopping the bridge belongs to the drive logic
  // A lock event during lock-off reloads the full time rather than adding to it
  logic [7:0] lockoff_cnt_q;
  logic [7:0] lockoff_cnt_d;
  always_comb begin
    lockoff_cnt_d = lockoff_cnt_q;
    if (lock_event_in) begin
      lockoff_cnt_d = cfg.lock_off_time;
    end else if (tick_step && lockoff_cnt_q != 8'h00) begin
      lockoff_cnt_d = lockoff_cnt_q - 8'h01;
    end
  end

  // Timer registers
  // Both timers share one reset and one clock with the rest of the block
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      blank_cnt_q <= 8'h00;
      blank_run_q <= 1'b0;
      lockoff_cnt_q <= 8'h00;
    end else begin
      blank_cnt_q <= blank_cnt_d;
      blank_run_q <= blank_run_d;
      lockoff_cnt_q <= lockoff_cnt_d;
    end
  end

  // Qualifying counters: a condition must hold whole seconds before it counts
  // Counters see only second ticks, so a condition starting just before a tick
  // qualifies up to one second early; a zero delay qualifies in the same cycle
  // Saturation instead of wrap-around keeps a long stay from looking short
  logic [4:0] low_secs_q;
  logic [4:0] high_secs_q;
  logic [4:0] off_secs_q;
  logic [4:0] low_secs_d;
  logic [4:0] high_secs_d;
  logic [4:0] off_secs_d;
  logic low_ok;
  logic high_ok;
  logic off_ok;
  assign low_ok = speed_low && (low_secs_q >= cfg.speed_fault_delay);
  assign high_ok = speed_high && (high_secs_q >= cfg.speed_fault_delay);
  assign off_ok = !speed_demand_on_in && (off_secs_q >= cfg.speed_fault_delay);

  // Saturating second counters, cleared as soon as the condition breaks
  function automatic logic [4:0] qual_next(input logic cond, input logic [4:0] secs, input logic tick);
    logic [4:0] nxt;
    nxt = secs;
    if (!cond) begin
      nxt = 5'h00;
    end else if (tick && secs != 5'h1F) begin
      nxt = secs + 5'h01;
    end
    return nxt;
  endfunction

  assign low_secs_d = qual_next(speed_low, low_secs_q, tick_second);
  assign high_secs_d = qual_next(speed_high, high_secs_q, tick_second);
  assign off_secs_d = qual_next(!speed_demand_on_in, off_secs_q, tick_second);

  // Qualifier registers
  // Reset clears the counters so no condition starts half-qualified
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      low_secs_q <= 5'h00;
      high_secs_q <= 5'h00;
      off_secs_q <= 5'h00;
    end else begin
      low_secs_q <= low_secs_d;
      high_secs_q <= high_secs_d;
      off_secs_q <= off_secs_d;
    end
  end

  // Lock event counter, used only in counting mode
  // Two bits suffice: the count saturates at the trip value, and every event trips
  // while at least one earlier event is still on record
  // Timed mode and the disabled function hold it at zero so a mode change starts clean
  logic [1:0] lock_cnt_q;
  logic [1:0] lock_cnt_d;
  logic lock_trip;
  assign lock_trip = !timed_mode && lock_event_in &&
    (lock_cnt_q >= rfi_pkg::LOCK_COUNT_TRIP - 2'h1);
  always_comb begin
    lock_cnt_d = lock_cnt_q;
    if (timed_mode || function_disabled) begin
      lock_cnt_d = 2'h0;
    end else if (lock_event_in) begin
      // A new event beats a clear in the same cycle
      if (lock_cnt_q != rfi_pkg::LOCK_COUNT_TRIP) begin
        lock_cnt_d = lock_cnt_q + 2'h1;
      end
    end else if (blank_end && speed_high) begin
      lock_cnt_d = 2'h0;
    end
  end

  // Flag state machine; priority runs from disable down to speed hysteresis
  // Priority, highest first:
  //   1. function disabled (flag mirrors end of open-loop start)
  //   2. counting mode with demand off (flag low at once)
  //   3. timed mode with demand off held for the delay (flag low)
  //   4. demand off otherwise (flag held)
  //   5. counting mode second lock event (flag high)
  //   6. end of blanking (low above recovery, high otherwise)
  //   7. low speed held for the delay (high; counting mode waits for blanking)
  //   8. high speed held for the delay once blanking is over (low)
  rfi_pkg::rfi_state_e state_q;
  rfi_pkg::rfi_state_e state_d;
  always_comb begin
    state_d = state_q;
    case (state_q)
      rfi_pkg::RFI_ST_DISABLED: begin
        if (!function_disabled) begin
          state_d = rfi_pkg::RFI_ST_NORMAL;
        end
      end
      rfi_pkg::RFI_ST_NORMAL, rfi_pkg::RFI_ST_FAULT: begin
        if (function_disabled) begin
          state_d = rfi_pkg::RFI_ST_DISABLED;
        end else if (!timed_mode && !speed_demand_on_in) begin
          state_d = rfi_pkg::RFI_ST_NORMAL;
        end else if (timed_mode && off_ok) begin
          state_d = rfi_pkg::RFI_ST_NORMAL;
        end else if (!speed_demand_on_in) begin
          state_d = state_q;
        end else if (lock_trip) begin
          state_d = rfi_pkg::RFI_ST_FAULT;
        end else if (blank_end) begin
          // Below recovery at blanking end is a fault even above the fault threshold
          state_d = speed_high ? rfi_pkg::RFI_ST_NORMAL : rfi_pkg::RFI_ST_FAULT;
        end else if (low_ok && (timed_mode || !blank_run_q)) begin
          state_d = rfi_pkg::RFI_ST_FAULT;
        end else if (high_ok && !blank_run_q) begin
          state_d = rfi_pkg::RFI_ST_NORMAL;
        end
      end
      default: begin
        state_d = rfi_pkg::RFI_ST_NORMAL;
      end
    endcase
  end

  // Flag output register; disabled mode mirrors end of open-loop start
  // Decoding from the next state keeps the pin one register from the decision,
  // so the flag never glitches while the state settles
  logic flag_q;
  logic flag_d;
  assign flag_d = (state_d == rfi_pkg::RFI_ST_DISABLED) ? start_done_in :
                  (state_d == rfi_pkg::RFI_ST_FAULT);

  // State registers
  // The lock counter sits here since it changes on the same decisions as the state
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= rfi_pkg::RFI_ST_NORMAL;
      lock_cnt_q <= 2'h0;
      flag_q <= 1'b0;
    end else begin
      state_q <= state_d;
      lock_cnt_q <= lock_cnt_d;
      flag_q <= flag_d;
    end
  end

  // Pin level read-back, three stages since the wire is shared with the outside
  // The level is taken only when the last two stages agree, so a one-cycle glitch
  // never reaches the status output; the cost is one extra cycle of latency
  logic [2:0] pin_sync_q;
  logic pin_level_q;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_sync_q <= 3'h0;
      pin_level_q <= 1'b0;
    end else begin
      pin_sync_q <= {pin_sync_q[1:0], fault_pin_in};
      if (pin_sync_q[1] == pin_sync_q[2]) begin
        pin_level_q <= pin_sync_q[2];
      end
    end
  end

  // Lock-off status register
  // Registered from the next count so the status lines up with the flag timing
  logic lockoff_active_q;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lockoff_active_q <= 1'b0;
    end else begin
      lockoff_active_q <= (lockoff_cnt_d != 8'h00);
    end
  end

  // Open drain: pull low for normal, release so the pull-up shows a fault
  // Data is tied low and only the enable moves, so the pin never drives high;
  // a fault needs the external pull-up, and another party may still hold it low
  assign fault_pin_out = 1'b0;
  assign fault_pin_oe_out = !flag_q;
  assign fault_state_out = flag_q;
  assign fault_pin_level_out = pin_level_q;
  assign lock_off_active_out = lockoff_active_q;
  assign max_electrical_frequency_out = cfg.max_electrical_frequency;

endmodule

`default_nettype wire

// ==== bench/rfi_rotor_fault_sva.sv ====
// Port-level assertions for the rotor fault indicator
`timescale 1ns/1ps
`default_nettype none
module rfi_rotor_fault_sva (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [15:0] cfg_word11_in,
  input wire logic [15:0] cfg_word12_in,
  input wire logic [15:0] cfg_word13_in,
  input wire logic [15:0] cfg_word15_in,
  input wire logic lock_event_in,
  input wire logic speed_demand_on_in,
  input wire logic start_done_in,
  input wire logic fault_pin_in,
  input wire logic fault_pin_out,
  input wire logic fault_pin_oe_out,
  input wire logic fault_state_out,
  input wire logic fault_pin_level_out,
  input wire logic lock_off_active_out,
  input wire logic [7:0] max_electrical_frequency_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  // Decoded enables; a zero recovery threshold switches the flag logic off
  wire logic en = cfg_word12_in[15:8] != 8'h00;
  wire logic mode = cfg_word15_in[2];
  wire logic run0 = en && !mode && speed_demand_on_in;
  flag_drive_a: assert property (fault_pin_oe_out == !fault_state_out && !fault_pin_out)
    else $error("flag pin drive wrong");
  disabled_start_a: assert property (!en |=> fault_state_out == $past(start_done_in))
    else $error("disabled flag not start-done");
  demand_off_a: assert property (en && !mode && !speed_demand_on_in |=> !fault_state_out)
    else $error("flag high with demand off");
  second_lock_a: assert property (run0 && lock_event_in ##1 run0 && lock_event_in |=> fault_state_out)
    else $error("second lock did not raise flag");
  timed_off_a: assert property (en && mode && !speed_demand_on_in && cfg_word13_in[12:8] == 5'h00
    |-> ##[1:3] !fault_state_out)
    else $error("timed mode demand off kept flag");
  max_freq_a: assert property (max_electrical_frequency_out == cfg_word11_in[7:0])
    else $error("frequency field wrong");
  lock_off_go_a: assert property (lock_event_in && cfg_word11_in[15:8] != 8'h00 |=> lock_off_active_out)
    else $error("lock-off did not start");
  lock_off_idle_a: assert property (cfg_word11_in[15:8] == 8'h00 && !lock_off_active_out && !lock_event_in
    |=> !lock_off_active_out)
    else $error("lock-off ran with zero time");
  pin_sync_a: assert property ($stable(fault_pin_in)[*4] |=> fault_pin_level_out == $past(fault_pin_in))
    else $error("wire level not followed");
endmodule
bind rfi_rotor_fault rfi_rotor_fault_sva rfi_rotor_fault_sva_inst (.*);
`default_nettype wire

// ==== bench/rfi_host_monitor.sv ====
// Host side of the open-drain flag wire: pull-up plus an optional second pull-down
`timescale 1ns/1ps
`default_nettype none
module rfi_host_monitor (
  input wire logic pin_data_in,
  input wire logic pin_oe_in,
  input wire logic host_pull_in,
  output logic wire_level_out
);
  // Wired-AND; the pull-up wins only when nobody pulls low
  assign wire_level_out = !(pin_oe_in && !pin_data_in) && !host_pull_in;
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
// Self-checking testbench for the rotor fault indicator
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [7:0] REC = 8'h10;
  localparam logic [7:0] FLT = 8'h08;
  logic mclk_in = 1'h0, rst_n_in = 1'h0, lock_event_in = 1'h0, speed_demand_on_in = 1'h1;
  logic start_done_in = 1'h1, host_pull = 1'h0, fault_pin_in, fault_pin_out, fault_pin_oe_out;
  logic fault_state_out, fault_pin_level_out, lock_off_active_out;
  logic [15:0] cfg_word11_in = 16'h3217, cfg_word12_in = 16'h0, cfg_word13_in = 16'h0;
  logic [15:0] cfg_word15_in = 16'h0, speed_rpm_in = 16'h0;
  logic [7:0] max_electrical_frequency_out;
  int band[5] = '{2, 0, 1, 2, 1};
  logic want[5] = '{1'h0, 1'h1, 1'h1, 1'h0, 1'h0};
  int err_total = 0;
  int comparisons = 0;
  // 200 MHz clock
  always #2.5 mclk_in = ~mclk_in;
  rfi_rotor_fault #(.TICK_CYCLES(10)) rfi_rotor_fault_inst (.*);
  rfi_host_monitor rfi_host_monitor_inst (.pin_data_in(fault_pin_out), .pin_oe_in(fault_pin_oe_out),
    .host_pull_in(host_pull), .wire_level_out(fault_pin_in));
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic cks(input logic e);
    chk("flag", 16'(fault_state_out), 16'(e));
  endtask
  // Inputs always move 1 ns after the rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic lock(input int n);
    repeat (n) begin
      lock_event_in = 1'h1;
      cyc(1);
    end
    lock_event_in = 1'h0;
  endtask
  // Fault threshold below recovery whenever the function is on, as the configurer must keep it
  task automatic cfg(input logic m, input logic [7:0] r, input logic [4:0] d, input logic [7:0] b);
    cfg_word12_in = {r, FLT};
    cfg_word13_in = {3'h0, d, b};
    cfg_word15_in = (16'($urandom) & 16'hFFFB) | {13'h0, m, 2'h0};
  endtask
  function automatic logic [15:0] rpm(input logic [7:0] c);
    return {4'h0, c, 4'h0};
  endfunction
  // Speed drawn below fault, between thresholds, or above recovery
  function automatic logic [15:0] speed_demand_input(input int b);
    logic [15:0] lo;
    logic [15:0] hi;
    lo = (b == 0) ? 16'h0 : (b == 1) ? rpm(FLT) : rpm(REC) + 16'h1;
    hi = (b == 0) ? rpm(FLT) : (b == 1) ? rpm(REC) : 16'hFFF;
    return lo + 16'($urandom % 32'(hi - lo));
  endfunction
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h11cd));
    cfg(1'h0, 8'h00, 5'h01, 8'h02);
    cyc(10);
    cks(1'h0);
    chk("oe", 16'(fault_pin_oe_out), 16'h1);
    rst_n_in = 1'h1;
    // Function off: flag follows start-done, wire follows flag and host pull
    repeat (8) begin
      start_done_in = 1'($urandom);
      host_pull = 1'($urandom);
      cfg_word11_in = {8'h00, 8'($urandom)};
      cyc(6);
      cks(start_done_in);
      chk("wire", 16'(fault_pin_level_out), 16'(start_done_in & ~host_pull));
      chk("maxf", 16'(max_electrical_frequency_out), 16'(cfg_word11_in[7:0]));
    end
    // Counting mode
    host_pull = 1'h0;
    speed_rpm_in = speed_demand_input(2);
    cfg(1'h0, REC, 5'h01, 8'h02);
    cyc(300);
    lock(1);
    cyc(2);
    cks(1'h0);
    cyc(38);
    cks(1'h0);
    lock(2);
    cyc(1);
    cks(1'h1);
    cyc(30);
    cks(1'h0);
    lock(1);
    cyc(2);
    cks(1'h0);
    cyc(38);
    cks(1'h0);
    speed_rpm_in = speed_demand_input(1);
    lock(1);
    cyc(30);
    cks(1'h1);
    // Hysteresis: high releases, low raises, between holds
    foreach (band[i]) begin
      speed_rpm_in = speed_demand_input(band[i]);
      cyc(210);
      cks(want[i]);
    end
    speed_rpm_in = speed_demand_input(0);
    cyc(210);
    speed_demand_on_in = 1'h0;
    cyc(2);
    cks(1'h0);
    lock(1);
    cyc(20);
    cks(1'h0);
    speed_demand_on_in = 1'h1;
    // Timed mode, blanking 40 steps, well past the time to reach recovery speed
    cfg(1'h1, REC, 5'h01, 8'h28);
    speed_rpm_in = speed_demand_input(2);
    cyc(450);
    cks(1'h0);
    speed_rpm_in = speed_demand_input(0);
    lock(1);
    cyc(215);
    cks(1'h1);
    speed_rpm_in = speed_demand_input(2);
    cyc(100);
    cks(1'h1);
    cyc(100);
    cks(1'h0);
    speed_rpm_in = speed_demand_input(1);
    lock(1);
    cyc(420);
    cks(1'h1);
    speed_demand_on_in = 1'h0;
    cyc(210);
    cks(1'h0);
    speed_demand_on_in = 1'h1;
    speed_rpm_in = speed_demand_input(0);
    cfg(1'h1, REC, 5'h00, 8'h28);
    cyc(5);
    cks(1'h1);
    speed_demand_on_in = 1'h0;
    cyc(3);
    cks(1'h0);
    // Lock-off at its default length
    cfg_word11_in = {rfi_pkg::LOCK_OFF_DEFAULT, 8'($urandom)};
    lock(1);
    cyc(1);
    chk("lockoff", 16'(lock_off_active_out), 16'h1);
    cyc(int'(rfi_pkg::LOCK_OFF_DEFAULT) * 10 - 15);
    chk("lockoff", 16'(lock_off_active_out), 16'h1);
    cyc(30);
    chk("lockoff", 16'(lock_off_active_out), 16'h0);
    results();
  end
  // Watchdog: the sequence needs about 4000 cycles
  initial begin
    #100000;
    err_total++;
    results();
  end
endmodule
`default_nettype wire
